// ---- logic/cat_regs.vh ----
`ifndef CAT_REGS_VH
`define CAT_REGS_VH
// ----------------------------------------------------------------
// Contract
// ----------------------------------------------------------------
// Contract
// - one chosen reference times everything
// - failed reference falls back to internal
// - drop/insert refused when disabled; reverts network
// - only data port one may be reference
// - external rate 2048/1544/8, default 1544
// - outgoing timing rates independent of reference; port one clock drops the 8 kbps data link only while port one is chosen
// - yellow alarm on both lines when enabled
// - drop/insert disabled: always yellow on network
// - yellow disabled: received yellow sends AIS
// - self-test at reset when enabled
// - timeout ends tests after set duration
// - duration 1 to 120 minutes, default 10
// - data link takes 8 kbps of port

// ----------------------------------------------------------------
// register offsets (word indices, compared directly with the bus address)
// ----------------------------------------------------------------
`define CAT_OFS_CTRL      4'h0
`define CAT_OFS_STATUS    4'h1
`define CAT_OFS_IRQ_STAT  4'h2
`define CAT_OFS_IRQ_MASK  4'h3
`define CAT_OFS_TEST      4'h4
`define CAT_OFS_PORT      4'h5

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CAT_CTRL_SRC_LSB  0
`define CAT_CTRL_EXT_LSB  4
`define CAT_CTRL_YEL_BIT  6
`define CAT_CTRL_DI_BIT   7
`define CAT_CTRL_ST_BIT   8
`define CAT_CTRL_TO_BIT   9
`define CAT_CTRL_DUR_LSB  16
// network source, 1544 rate, yellow, drop/insert, self-test on, 10 minutes
`define CAT_CTRL_RESET    32'h000A_01D0
`define CAT_PORT_RESET    11'h040

// ----------------------------------------------------------------
// reference source and external rate codes
// ----------------------------------------------------------------
`define CAT_SRC_NET       3'h0
`define CAT_SRC_DI        3'h1
`define CAT_SRC_INT       3'h2
`define CAT_SRC_EXT       3'h3
`define CAT_SRC_PORT1     3'h4
`define CAT_EXT_2048      2'h0
`define CAT_EXT_1544      2'h1
`define CAT_EXT_8         2'h2

// ----------------------------------------------------------------
// interrupt bits
// ----------------------------------------------------------------
`define CAT_IRQ_FALLBACK  0
`define CAT_IRQ_TEST_END  1
`define CAT_IRQ_ST_DONE   2
`define CAT_IRQ_DI_REVERT 3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
// one minute of the 250 MHz clock; needs 34 bits
`define CAT_MINUTE_CYC    34'h3_7E11_D600
`define CAT_REF_WINDOW    14'h2000
`define CAT_LOSS_EDGES    8'h04
`define CAT_ST_CYCLES     16'h0400
`define CAT_DUR_MIN       7'h01
`define CAT_DUR_MAX       7'h78
`define CAT_DL_KBPS       11'h008
`endif

// ---- logic/cat_control.v ----
`timescale 1ns/1ps
`include "cat_regs.vh"
module cat_control #(
  parameter [33:0] MINUTE_CYCLES = `CAT_MINUTE_CYC,
  parameter [13:0] REF_WINDOW    = `CAT_REF_WINDOW
) (
  input  wire        clk_sys_i,
  input  wire        rstn_i,
  input  wire [3:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output reg         avs_waitrequest_o,
  input  wire        ref_net_i,
  input  wire        ref_di_i,
  input  wire        ref_ext_i,
  input  wire        ref_port1_i,
  input  wire        yellow_cond_i,
  input  wire        yellow_rx_net_i,
  input  wire        test_start_i,
  input  wire        test_stop_i,
  input  wire        self_test_ok_i,
  output reg  [2:0]  ref_sel_o,
  output reg  [1:0]  ext_rate_o,
  output reg         on_internal_o,
  output reg         yellow_net_o,
  output reg         yellow_di_o,
  output reg         ais_di_o,
  output reg         self_test_run_o,
  output reg         test_active_o,
  output reg  [10:0] port1_clk_kbps_o,
  output reg  [10:0] port1_user_kbps_o,
  output reg         irq_o
);

  // ----------------------------------------------------------------
  // configuration and status state
  // ----------------------------------------------------------------
  reg  [31:0] ctrl;            // software control word
  reg  [3:0]  irq_stat;        // sticky events
  reg  [3:0]  irq_mask;        // enables per event
  reg  [10:0] port_rate;       // port one rate in kbps
  reg         port_dl_en;      // embedded_data_link on port one
  reg         ref_lost;        // selected reference declared lost
  reg  [7:0]  miss_cnt;        // windows without an edge
  reg  [13:0] win_cnt;         // edge search window
  reg         ref_prev;        // last sample of chosen reference
  reg         seen_edge;       // edge within current window
  reg  [33:0] min_cnt;         // cycles within one minute
  reg  [6:0]  minutes;         // minutes of running test
  reg  [15:0] st_cnt;          // self-test length
  reg         st_pending;      // self-test due after reset
  reg  [3:0]  ev;              // events raised this cycle

  wire [2:0]  src      = ctrl[`CAT_CTRL_SRC_LSB+2:`CAT_CTRL_SRC_LSB];
  wire [1:0]  ext_rate = ctrl[`CAT_CTRL_EXT_LSB+1:`CAT_CTRL_EXT_LSB];
  wire        yel_en   = ctrl[`CAT_CTRL_YEL_BIT];
  wire        di_en    = ctrl[`CAT_CTRL_DI_BIT];
  wire        st_en    = ctrl[`CAT_CTRL_ST_BIT];
  wire        to_en    = ctrl[`CAT_CTRL_TO_BIT];
  wire [6:0]  dur      = ctrl[`CAT_CTRL_DUR_LSB+6:`CAT_CTRL_DUR_LSB];
  wire        acc      = (avs_read_i | avs_write_i) & avs_waitrequest_o;
  // a write lands only at the edge where waitrequest is seen low
  wire        wr_done  = avs_write_i & ~avs_waitrequest_o;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // merge a write word into a register under byte enables
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          merge[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  // pick the level of the chosen reference
  function ref_level;
    input [2:0] s;
    begin
      case (s)
        `CAT_SRC_NET:   ref_level = ref_net_i;
        `CAT_SRC_DI:    ref_level = ref_di_i;
        `CAT_SRC_EXT:   ref_level = ref_ext_i;
        `CAT_SRC_PORT1: ref_level = ref_port1_i;
        default:        ref_level = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // bus and configuration
  // ----------------------------------------------------------------
  // control word as it would stand after the pending write
  wire [31:0] ctrl_wr = merge(ctrl, avs_writedata_i, avs_byteenable_i);

  // one wait cycle then answer; writes land in the answering cycle
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
      ctrl              <= `CAT_CTRL_RESET;
      irq_mask          <= 4'h0;
      port_rate         <= `CAT_PORT_RESET;
      port_dl_en        <= 1'b0;
    end else begin
      avs_waitrequest_o <= ~acc;
      if (wr_done) begin
        if (avs_address_i == `CAT_OFS_CTRL) begin
          ctrl <= ctrl_wr;
          // drop/insert choice refused while that line is off
          if (avs_byteenable_i[0] && !ctrl_wr[`CAT_CTRL_DI_BIT]
              && avs_writedata_i[2:0] == `CAT_SRC_DI) begin
            ctrl[2:0] <= src;
          end
          // only the three documented rates are taken
          if (avs_byteenable_i[0] && avs_writedata_i[5:4] == 2'h3) begin
            ctrl[5:4] <= ext_rate;
          end
          // other source codes (data ports two up) are refused
          if (avs_byteenable_i[0] && avs_writedata_i[2:0] > `CAT_SRC_PORT1) begin
            ctrl[2:0] <= src;
          end
          // duration kept within one to 120 minutes
          if (avs_byteenable_i[2] && (avs_writedata_i[22:16] < `CAT_DUR_MIN ||
              avs_writedata_i[22:16] > `CAT_DUR_MAX)) begin
            ctrl[22:16] <= dur;
          end
        end else if (avs_address_i == `CAT_OFS_IRQ_MASK) begin
          irq_mask <= avs_writedata_i[3:0];
        end else if (avs_address_i == `CAT_OFS_PORT) begin
          port_rate  <= avs_writedata_i[10:0];
          port_dl_en <= avs_writedata_i[16];
        end
      end
      // line disabled while chosen: reference moves to network
      if (!di_en && src == `CAT_SRC_DI) begin
        ctrl[2:0] <= `CAT_SRC_NET;
      end
      if (acc && avs_read_i) begin
        if (avs_address_i == `CAT_OFS_CTRL) begin
          // rate field hidden unless external is chosen
          avs_readdata_o <= (src == `CAT_SRC_EXT) ? ctrl : (ctrl & 32'hFFFF_FFCF);
        end else if (avs_address_i == `CAT_OFS_STATUS) begin
          avs_readdata_o <= {25'h0, test_active_o, self_test_run_o, ref_lost, on_internal_o, ref_sel_o};
        end else if (avs_address_i == `CAT_OFS_IRQ_STAT) begin
          avs_readdata_o <= {28'h0, irq_stat};
        end else if (avs_address_i == `CAT_OFS_IRQ_MASK) begin
          avs_readdata_o <= {28'h0, irq_mask};
        end else if (avs_address_i == `CAT_OFS_TEST) begin
          avs_readdata_o <= {25'h0, minutes};
        end else if (avs_address_i == `CAT_OFS_PORT) begin
          avs_readdata_o <= {15'h0, port_dl_en, 5'h0, port_rate};
        end else begin
          avs_readdata_o <= 32'h0000_0000;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // reference monitor and fallback
  // ----------------------------------------------------------------
  // counts windows with no edge; a few in a row declare loss
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      ref_prev  <= 1'b0;
      seen_edge <= 1'b0;
      win_cnt   <= 14'h0000;
      miss_cnt  <= 8'h00;
      ref_lost  <= 1'b0;
    end else begin
      ref_prev <= ref_level(src);
      if (src == `CAT_SRC_INT) begin
        ref_lost  <= 1'b0;
        miss_cnt  <= 8'h00;
        seen_edge <= 1'b0;
        win_cnt   <= 14'h0000;
      end else if (win_cnt == REF_WINDOW - 14'h0001) begin
        win_cnt <= 14'h0000;
        seen_edge <= 1'b0;
        if (seen_edge) begin
          miss_cnt <= 8'h00;
          ref_lost <= 1'b0;
        end else if (miss_cnt == `CAT_LOSS_EDGES - 8'h01) begin
          ref_lost <= 1'b1; // loss after missed edges
        end else begin
          miss_cnt <= miss_cnt + 8'h01;
        end
      end else begin
        win_cnt <= win_cnt + 14'h0001;
        if (ref_level(src) != ref_prev) begin
          seen_edge <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // timing, alarm and rate outputs
  // ----------------------------------------------------------------
  // all timing follows one source; fallback to internal on loss
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      ref_sel_o         <= `CAT_SRC_NET;
      on_internal_o     <= 1'b0;
      ext_rate_o        <= `CAT_EXT_1544;
      yellow_net_o      <= 1'b0;
      yellow_di_o       <= 1'b0;
      ais_di_o          <= 1'b0;
      port1_clk_kbps_o  <= 11'h000;
      port1_user_kbps_o <= 11'h000;
    end else begin
      ref_sel_o     <= ref_lost ? `CAT_SRC_INT : src;
      on_internal_o <= ref_lost | (src == `CAT_SRC_INT);
      // ext rate only sets the input divider; output rates stay fixed
      ext_rate_o    <= ext_rate;
      // drop/insert off forces yellow on network
      yellow_net_o  <= yellow_cond_i & (yel_en | ~di_en);
      yellow_di_o   <= yellow_cond_i & yel_en & di_en;
      ais_di_o      <= yellow_rx_net_i & ~yel_en & di_en;
      // data link takes its share of the port
      port1_user_kbps_o <= port_dl_en ? port_rate - `CAT_DL_KBPS : port_rate;
      // expected attached-equipment clock when port one times us
      port1_clk_kbps_o  <= (src == `CAT_SRC_PORT1 && port_dl_en) ? port_rate - `CAT_DL_KBPS : port_rate;
    end
  end

  // ----------------------------------------------------------------
  // self-test and test timeout
  // ----------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      st_pending      <= 1'b1;
      self_test_run_o <= 1'b0;
      st_cnt          <= 16'h0000;
      test_active_o   <= 1'b0;
      min_cnt         <= 34'h0_0000_0000;
      minutes         <= 7'h00;
      ev              <= 4'h0;
    end else begin
      ev <= 4'h0;
      ev[`CAT_IRQ_FALLBACK]  <= ref_lost & ~on_internal_o;
      ev[`CAT_IRQ_DI_REVERT] <= ~di_en & (src == `CAT_SRC_DI);
      // run after reset only when enabled
      if (st_pending) begin
        st_pending      <= 1'b0;
        self_test_run_o <= st_en;
        st_cnt          <= 16'h0000;
      end else if (self_test_run_o) begin
        if (st_cnt == `CAT_ST_CYCLES - 16'h0001) begin
          self_test_run_o         <= 1'b0;
          ev[`CAT_IRQ_ST_DONE]    <= self_test_ok_i;
        end else begin
          st_cnt <= st_cnt + 16'h0001;
        end
      end
      // tests end by hand, or by timer when enabled
      if (test_stop_i) begin
        test_active_o <= 1'b0;
      end else if (test_start_i && !test_active_o) begin
        test_active_o <= 1'b1;
        min_cnt       <= 34'h0_0000_0000;
        minutes       <= 7'h00;
      end else if (test_active_o && to_en) begin
        if (min_cnt == MINUTE_CYCLES - 34'h0_0000_0001) begin
          min_cnt <= 34'h0_0000_0000;
          if (minutes + 7'h01 >= dur) begin
            test_active_o         <= 1'b0;
            ev[`CAT_IRQ_TEST_END] <= 1'b1;
          end else begin
            minutes <= minutes + 7'h01;
          end
        end else begin
          min_cnt <= min_cnt + 34'h0_0000_0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupts: set wins over write-one-to-clear
  // ----------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      irq_stat <= 4'h0;
      irq_o    <= 1'b0;
    end else begin
      if (wr_done && avs_address_i == `CAT_OFS_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~avs_writedata_i[3:0]) | ev;
      end else begin
        irq_stat <= irq_stat | ev;
      end
      irq_o <= |(irq_stat & irq_mask);
    end
  end

endmodule

// ---- testbench/cat_far_end.sv ----
`timescale 1ns/1ps
// ------------------------------
// far side: line and equipment
// ------------------------------
module cat_far_end (
  input  wire       clk_sys_i,
  input  wire [3:0] live_i,    // which refs run
  input  wire       yel_req_i, // network sends yellow
  output reg  [3:0] ref_o,     // net, di, ext, port1
  output wire       yel_rx_o   // yellow seen by block
);
  reg [1:0] div; // refs toggle every fourth clock, an eighth of its rate
  initial begin
    div = 2'h0;
    ref_o = 4'h0;
  end
  // a dead ref freezes like a cut line; all live refs toggle together
  always @(posedge clk_sys_i) begin
    div <= div + 2'h1;
    if (div == 2'h3) begin
      ref_o <= ref_o ^ live_i;
    end
  end
  // equipment yellow reaches us via network
  assign yel_rx_o = yel_req_i;
endmodule

// ---- testbench/cat_control_monitor.sv ----
`timescale 1ns/1ps
// ------------------------------
// port checks
// ------------------------------
module cat_control_monitor (
  input wire        clk_sys_i,
  input wire        rstn_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire        avs_waitrequest_o,
  input wire        yellow_cond_i,
  input wire        yellow_rx_net_i,
  input wire [2:0]  ref_sel_o,
  input wire [1:0]  ext_rate_o,
  input wire        on_internal_o,
  input wire        yellow_net_o,
  input wire        yellow_di_o,
  input wire        ais_di_o,
  input wire        self_test_run_o,
  input wire        test_active_o,
  input wire [10:0] port1_user_kbps_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  property p_ans; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
  a_ans: assert property (p_ans) else $error("no answer next cycle");
  property p_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  a_one: assert property (p_one) else $error("answer held too long");
  property p_ext; ext_rate_o != 2'h3; endproperty
  a_ext: assert property (p_ext) else $error("bad external rate");
  property p_src; ref_sel_o <= 3'h4; endproperty
  a_src: assert property (p_src) else $error("bad source");
  property p_fall; on_internal_o |-> ref_sel_o == 3'h2; endproperty
  a_fall: assert property (p_fall) else $error("fallback not internal");
  property p_both; yellow_di_o |-> yellow_net_o; endproperty
  a_both: assert property (p_both) else $error("yellow on one line only");
  property p_ais; ais_di_o |-> !yellow_di_o && ($past(yellow_rx_net_i) || $past(yellow_rx_net_i, 2)); endproperty
  a_ais: assert property (p_ais) else $error("ais without cause");
  property p_ycause; yellow_net_o |-> $past(yellow_cond_i) || $past(yellow_cond_i, 2); endproperty
  a_ycause: assert property (p_ycause) else $error("yellow without cause");
  property p_st; $rose(rstn_i) |=> self_test_run_o; endproperty
  a_st: assert property (p_st) else $error("self-test not started");
  property p_port; $changed(port1_user_kbps_o) && $past(rstn_i, 2) |-> $past(avs_write_i, 2); endproperty
  a_port: assert property (p_port) else $error("user rate moved alone");
  c_fall: cover property (on_internal_o);
  c_ais: cover property (ais_di_o);
  c_test: cover property ($fell(test_active_o));
endmodule
bind cat_control cat_control_monitor u_mon (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o), .yellow_cond_i(yellow_cond_i),
  .yellow_rx_net_i(yellow_rx_net_i), .ref_sel_o(ref_sel_o), .ext_rate_o(ext_rate_o), .on_internal_o(on_internal_o),
  .yellow_net_o(yellow_net_o), .yellow_di_o(yellow_di_o), .ais_di_o(ais_di_o), .self_test_run_o(self_test_run_o),
  .test_active_o(test_active_o), .port1_user_kbps_o(port1_user_kbps_o));

// ---- testbench/cat_control_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(n,e,g) begin cmp_count++; if ((g)!==(e)) begin err_count++; $display("[FAIL] %s exp %0h got %0h",n,e,g); end end
`define WT(c,n) begin k=0; while(!(c)&&k<n) begin @(posedge clk_sys_i); k++; end if(!(c)) hang; end
// ------------------------------
// bench for the control block
// ------------------------------
module cat_control_tb_top;
  reg         clk_sys_i, rstn_i, rd, wr, ycond, yreq, tgo, tstop;
  reg  [3:0]  adr, live;
  reg  [31:0] wd, q;
  reg  [4:0]  i;
  wire [31:0] rdat;
  wire [3:0]  refs;
  wire [2:0]  sel;
  wire [1:0]  ext;
  wire [10:0] pclk, puser;
  wire        wreq, yrx, oint, ynet, ydi, ais, strun, tact, irq;
  integer     err_count, cmp_count, k;
  always #2 clk_sys_i = ~clk_sys_i;
  cat_far_end u_cat_far_end (.clk_sys_i(clk_sys_i), .live_i(live), .yel_req_i(yreq), .ref_o(refs), .yel_rx_o(yrx));
  cat_control #(.MINUTE_CYCLES(100), .REF_WINDOW(64)) u_cat_control (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .ref_net_i(refs[0]), .ref_di_i(refs[1]), .ref_ext_i(refs[2]),
    .ref_port1_i(refs[3]), .yellow_cond_i(ycond), .yellow_rx_net_i(yrx), .test_start_i(tgo), .test_stop_i(tstop),
    .self_test_ok_i(1'b1), .ref_sel_o(sel), .ext_rate_o(ext), .on_internal_o(oint), .yellow_net_o(ynet),
    .yellow_di_o(ydi), .ais_di_o(ais), .self_test_run_o(strun), .test_active_o(tact), .port1_clk_kbps_o(pclk),
    .port1_user_kbps_o(puser), .irq_o(irq));
  // control word: source, ext rate, yellow, drop/insert, timeout, minutes
  function [31:0] cv(input [2:0] s, input [1:0] e, input y, input di, input to, input [6:0] d);
    cv = {9'h000, d, 6'h00, to, 1'b1, di, y, e, 1'b0, s};
  endfunction
  task give_verdict;
    begin
      $display("errors %0d checks %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) begin
        $display("DONE - PASS");
      end else begin
        $display("DONE - FAIL");
      end
      $finish;
    end
  endtask
  task hang;
    begin
      err_count++;
      $display("[FAIL] wait exp 1 got 0");
      give_verdict;
    end
  endtask
  // one bus cycle, held until waitrequest is sampled low
  task bus(input w, input [3:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk_sys_i);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      n = 0;
      do begin
        @(posedge clk_sys_i);
        n++;
      end while (wreq !== 1'b0 && n < 20);
      if (wreq !== 1'b0) hang;
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
    end
  endtask
  // one-cycle start (0) or stop (1) strobe, then three quiet cycles
  task pulse(input stop);
    begin
      if (stop) begin
        tstop <= 1'b1;
      end else begin
        tgo <= 1'b1;
      end
      @(posedge clk_sys_i);
      tgo <= 1'b0;
      tstop <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
    end
  endtask
  initial begin
    {clk_sys_i, rstn_i, rd, wr, ycond, yreq, tgo, tstop} = 8'h00;
    {adr, wd, live, err_count, cmp_count} = 0;
    live = 4'hF;
    repeat (12) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    bus(0, 4'h0, 0);
    `CHK("ctrl", 32'h000A01C0, q)
    `CHK("ext_def", 2'h1, ext)
    `CHK("strun", 1'b1, strun)
    bus(0, 4'h5, 0);
    `CHK("port", 32'h00000040, q)
    bus(0, 4'hF, 0);
    `CHK("unmapped", 32'h0, q)
    `WT(strun === 1'b0, 1100)
    bus(0, 4'h2, 0);
    `CHK("st_done", 32'h4, q)
    `CHK("irq_off", 1'b0, irq)
    bus(1, 4'h3, 32'hF);
    `WT(irq === 1'b1, 4)
    bus(1, 4'h2, 32'h4);
    `WT(irq === 1'b0, 4)
    bus(1, 4'h5, 32'h00010040);
    bus(1, 4'h0, cv(4, 0, 1, 1, 0, 10));
    bus(1, 4'h0, cv(5, 0, 1, 1, 0, 10));
    bus(0, 4'h0, 0);
    `CHK("src5", 3'h4, q[2:0])
    `CHK("sel", 3'h4, sel)
    `CHK("user", 11'd56, puser)
    `CHK("pclk", 11'd56, pclk)
    for (i = 0; i < 4; i++) begin
      bus(1, 4'h0, cv(3, i[1:0], 1, 1, 0, 10));
      bus(0, 4'h0, 0);
      `CHK("ext", (i == 3) ? 2'h2 : i[1:0], ext)
      `CHK("ext_rd", (i == 3) ? 2'h2 : i[1:0], q[5:4])
    end
    bus(1, 4'h0, cv(0, 2, 1, 1, 0, 10));
    bus(0, 4'h0, 0);
    `CHK("ext_hid", 2'h0, q[5:4])
    live <= 4'hB;
    bus(1, 4'h0, cv(3, 1, 1, 1, 0, 10));
    `WT(oint === 1'b1, 600)
    repeat (2) @(posedge clk_sys_i);
    `CHK("fb_sel", 3'h2, sel)
    `CHK("fb_irq", 1'b1, irq)
    bus(0, 4'h2, 0);
    `CHK("fb_bit", 1'b1, q[0])
    live <= 4'hF;
    `WT(oint === 1'b0, 200)
    bus(1, 4'h2, 32'hF);
    bus(1, 4'h0, cv(1, 0, 1, 1, 0, 10));
    bus(1, 4'h0, cv(1, 0, 1, 0, 0, 10));
    `WT(sel === 3'h0, 4)
    bus(0, 4'h2, 0);
    `CHK("revert", 1'b1, q[3])
    bus(1, 4'h0, cv(1, 0, 1, 0, 0, 10));
    bus(0, 4'h0, 0);
    `CHK("di_refused", 3'h0, q[2:0])
    for (i = 0; i < 16; i++) begin
      bus(1, 4'h0, cv(0, 0, i[0], i[1], 0, 10));
      ycond <= i[2];
      yreq <= i[3];
      repeat (4) @(posedge clk_sys_i);
      `CHK("ynet", i[2] & (i[0] | ~i[1]), ynet)
      `CHK("ydi", i[2] & i[0] & i[1], ydi)
      `CHK("ais", i[3] & ~i[0] & i[1], ais)
    end
    bus(1, 4'h0, cv(0, 0, 1, 1, 1, 0));
    bus(1, 4'h0, cv(0, 0, 1, 1, 1, 121));
    bus(0, 4'h0, 0);
    `CHK("dur", 7'h0A, q[22:16])
    bus(1, 4'h0, cv(0, 0, 1, 1, 1, 1));
    pulse(0);
    `CHK("active", 1'b1, tact)
    `WT(tact === 1'b0, 300)
    bus(0, 4'h2, 0);
    `CHK("t_end", 1'b1, q[1])
    bus(1, 4'h0, cv(0, 0, 1, 1, 0, 1));
    pulse(0);
    repeat (300) @(posedge clk_sys_i);
    `CHK("manual", 1'b1, tact)
    pulse(1);
    `CHK("stopped", 1'b0, tact)
    give_verdict;
  end
endmodule
